//--- shared/adcp_pkg.sv
// package for the sample output pipeline of a 10-bit converter
// assumes one clock domain (mclk) and a digitised sample arriving from the analog front end
// Contract
// - a new sample is taken on every rising edge of the sampling clock.
// - the output word and over-range flag change only on rising sampling clock edges.
// - a sample's result appears at the outputs 3 sampling clock cycles after it was taken.
// - the output code is 10 bits wide, splitting the reference span into 1024 steps.
// - the over-range flag is low normally and high for a sample above the top reference.
// - while the over-range flag is high every output bit is forced to one.
// - output enable high puts all data outputs and the over-range flag in high impedance.
// - output enable acts without the clock and touches only the output drivers.
// - the internal output register keeps updating while the outputs are three-stated.
// - sleep control high stops operation and floats the outputs; low runs normally.
// - output bit 0 is the least significant bit and bit 9 the most significant.
package adcp_pkg;
  localparam int ADCP_CODE_W = 10;
  localparam int ADCP_STEPS = 1024;
  localparam int ADCP_LATENCY = 3;
  localparam int ADCP_FIFO_DEPTH = 8;
  localparam int ADCP_SYNC_STAGES = 2;
  localparam logic [ADCP_CODE_W-1:0] ADCP_FULL_SCALE = 10'h3FF;
  localparam logic [ADCP_CODE_W-1:0] ADCP_ZERO_CODE = 10'h000;
  localparam logic [ADCP_CODE_W:0] ADCP_RAW_TOP = 11'h3FF;

  typedef struct packed {
    logic over_range_flag;
    logic [ADCP_CODE_W-1:0] sample_word;
  } adcp_result_s;

  typedef enum logic [1:0] {
    ADCP_RUN = 2'b00,
    ADCP_SLEEP = 2'b01,
    ADCP_WAKE = 2'b10
  } adcp_state_e;
endpackage

//--- rtl/adcp_fifo.sv
// small flop-based fifo carrying results toward the output register
// assumes source and sink on the same clock
`timescale 1ns/1ps
module adcp_fifo import adcp_pkg::*; #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  // full compare needs the extra count bit: DEPTH does not fit in AW bits
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH)) || out_ready;
  assign out_valid = cnt_ff != '0;
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || clr) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- rtl/adcp_top.sv
// sample-to-pin pipeline: sampling, 3-stage latency, over-range clamp, three-state drive
// assumes a digitised raw value (11 bits, top bit = above top reference) from the front end
// and that sample_clk, output_enable_n and sleep_control are pins outside mclk's domain
`timescale 1ns/1ps
module adcp_top import adcp_pkg::*; #(
  parameter int CODE_W = ADCP_CODE_W,
  parameter int LATENCY = ADCP_LATENCY,
  parameter int FIFO_DEPTH = ADCP_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sample_clk,
  input wire logic [ADCP_CODE_W:0] raw_level,
  input wire logic output_enable_n,
  input wire logic sleep_control,
  output logic [ADCP_CODE_W-1:0] sample_word_o,
  output logic [ADCP_CODE_W-1:0] sample_word_oe_n,
  output logic over_range_flag_o,
  output logic over_range_flag_oe_n,
  output logic sample_strobe,
  output logic overflow_lost
);
  logic [ADCP_SYNC_STAGES-1:0] clk_sync_ff;
  logic [ADCP_SYNC_STAGES-1:0] sleep_sync_ff;
  logic clk_prev_ff;
  logic rise;
  adcp_state_e state_ff;
  adcp_state_e nxt_state;
  adcp_result_s stage_ff [LATENCY];
  logic [LATENCY-1:0] stage_vld_ff;
  adcp_result_s conv;
  adcp_result_s fifo_out;
  adcp_result_s out_ff;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic running;
  logic drive;
  logic lost_ff;

  // clamp and code one raw level into a result
  function automatic adcp_result_s code_result(input logic [ADCP_CODE_W:0] lvl);
    adcp_result_s r;
    r.over_range_flag = lvl > ADCP_RAW_TOP;
    r.sample_word = r.over_range_flag ? ADCP_FULL_SCALE : lvl[ADCP_CODE_W-1:0];
    return r;
  endfunction

  // only the second stage is read: first stage may be metastable
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clk_sync_ff <= '0;
      sleep_sync_ff <= '1;
    end else begin
      clk_sync_ff <= {clk_sync_ff[0], sample_clk};
      sleep_sync_ff <= {sleep_sync_ff[0], sleep_control};
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clk_prev_ff <= 1'b0;
    end else begin
      clk_prev_ff <= clk_sync_ff[1];
    end
  end

  assign rise = clk_sync_ff[1] && !clk_prev_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ADCP_RUN: begin
        if (sleep_sync_ff[1]) begin
          nxt_state = ADCP_SLEEP;
        end
      end
      ADCP_SLEEP: begin
        if (!sleep_sync_ff[1]) begin
          nxt_state = ADCP_WAKE;
        end
      end
      ADCP_WAKE: begin
        nxt_state = sleep_sync_ff[1] ? ADCP_SLEEP : ADCP_RUN;
      end
      default: begin
        nxt_state = ADCP_SLEEP;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_ff <= ADCP_SLEEP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign running = (state_ff == ADCP_RUN) && !sleep_sync_ff[1];
  assign conv = code_result(raw_level);

  // latency pipe advances only on sampling edges; oe has no say here
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stage_vld_ff <= '0;
    end else if (!running) begin
      stage_vld_ff <= '0;
    end else if (rise) begin
      stage_vld_ff <= {stage_vld_ff[LATENCY-2:0], 1'b1};
    end
  end

  always_ff @(posedge mclk) begin
    if (running && rise) begin
      stage_ff[0] <= conv;
    end
  end

  genvar g;
  generate
    for (g = 1; g < LATENCY; g++) begin : g_pipe
      always_ff @(posedge mclk) begin
        if (running && rise) begin
          stage_ff[g] <= stage_ff[g-1];
        end
      end
    end
  endgenerate

  // last stage feeds the fifo on the edge that completes the latency
  adcp_fifo #(
    .WIDTH($bits(adcp_result_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .clr(!running),
    .in_valid(running && rise && stage_vld_ff[LATENCY-1]),
    .in_ready(fifo_in_ready),
    .in_data(stage_ff[LATENCY-1]),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out)
  );

  // fifo drains immediately, so output lands on the 3rd edge; word never lost in practice
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      out_ff <= '{over_range_flag: 1'b0, sample_word: ADCP_ZERO_CODE};
    end else if (fifo_out_valid) begin
      out_ff <= fifo_out;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= fifo_out_valid;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lost_ff <= 1'b0;
    end else if (running && rise && stage_vld_ff[LATENCY-1] && !fifo_in_ready) begin
      lost_ff <= 1'b1;
    end
  end

  assign overflow_lost = lost_ff;
  assign sample_word_o = out_ff.sample_word;
  assign over_range_flag_o = out_ff.over_range_flag;

  // raw pin used, not the synchronised copy: drivers follow oe without the clock
  assign drive = !output_enable_n && !sleep_control;
  assign sample_word_oe_n = {ADCP_CODE_W{!drive}};
  assign over_range_flag_oe_n = !drive;
endmodule

//--- dv/adcp_capture_model.sv
// capture latch on the far side: resolves each output pin, latches it on the strobe
// assumes a floated pin reads back as a level that flips every cycle
`timescale 1ns/1ps
module adcp_capture_model import adcp_pkg::*; (
  input wire logic mclk,
  input wire logic [ADCP_CODE_W-1:0] sample_word_o,
  input wire logic [ADCP_CODE_W-1:0] sample_word_oe_n,
  input wire logic over_range_flag_o,
  input wire logic over_range_flag_oe_n,
  input wire logic sample_strobe,
  output adcp_result_s cap
);
  adcp_result_s pin_ff = '0;
  adcp_result_s bus;
  // no pull on these lines, so a floated bit must not look like a held value
  assign bus.sample_word = (sample_word_o & ~sample_word_oe_n)
    | (~pin_ff.sample_word & sample_word_oe_n);
  assign bus.over_range_flag = over_range_flag_oe_n ? ~pin_ff.over_range_flag
    : over_range_flag_o;
  always_ff @(posedge mclk) pin_ff <= bus;
  always_ff @(posedge mclk) if (sample_strobe) cap <= bus;
endmodule

//--- dv/adcp_checker.sv
// pin-level checks on the sample output pipeline
// assumes one clock, mclk, and a synchronous active-low reset
`timescale 1ns/1ps
module adcp_checker import adcp_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic output_enable_n,
  input wire logic sleep_control,
  input wire logic [ADCP_CODE_W-1:0] sample_word_o,
  input wire logic [ADCP_CODE_W-1:0] sample_word_oe_n,
  input wire logic over_range_flag_o,
  input wire logic over_range_flag_oe_n,
  input wire logic sample_strobe,
  input wire logic overflow_lost
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  oe_float_a: assert property (output_enable_n
    |-> &{sample_word_oe_n, over_range_flag_oe_n}) else $error("drive while disabled");
  sleep_float_a: assert property (sleep_control
    |-> &{sample_word_oe_n, over_range_flag_oe_n}) else $error("drive while asleep");
  oe_drive_a: assert property (!output_enable_n && !sleep_control
    |-> {over_range_flag_oe_n, sample_word_oe_n} == 11'h000) else $error("not driving");
  oe_async_a: assert property ($changed(output_enable_n) && !sleep_control
    |-> over_range_flag_oe_n == output_enable_n) else $error("enable lags pin");
  clamp_full_a: assert property (over_range_flag_o
    |-> sample_word_o == ADCP_FULL_SCALE) else $error("flag without full scale");
  word_edge_a: assert property ($changed(sample_word_o) && !sleep_control
    |-> sample_strobe) else $error("word moved off a sampling edge");
  strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe longer than one cycle");
  no_loss_a: assert property (!overflow_lost) else $error("sample dropped");
endmodule
bind adcp_top adcp_checker u_chk (.mclk, .nrst, .output_enable_n, .sleep_control,
  .sample_word_o, .sample_word_oe_n, .over_range_flag_o, .over_range_flag_oe_n,
  .sample_strobe, .overflow_lost);

//--- dv/testbench.sv
// self-checking bench: codes, latency, clamp, output enable, sleep
// assumes the capture model on the output pins and the bound checker
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench import adcp_pkg::*;;
  // trailing zeros only push the last real code through the 3-deep pipe
  localparam logic [ADCP_CODE_W:0] CODES [12] = '{11'h000, 11'h001, 11'h200,
    11'h3FF, 11'h155, 11'h2AA, 11'h400, 11'h7FF, 11'h0AA, 11'h000, 11'h000, 11'h000};
  logic mclk = 0, nrst = 0, sample_clk = 0, output_enable_n = 0, sleep_control = 0;
  logic [ADCP_CODE_W:0] raw_level = '0;
  logic [ADCP_CODE_W-1:0] sample_word_o, sample_word_oe_n;
  logic over_range_flag_o, over_range_flag_oe_n, sample_strobe, overflow_lost;
  adcp_result_s cap;
  adcp_result_s exp_q[$];
  int errors = 0, checks_done = 0;
  adcp_top u_dut (.mclk, .nrst, .sample_clk, .raw_level, .output_enable_n,
    .sleep_control, .sample_word_o, .sample_word_oe_n, .over_range_flag_o,
    .over_range_flag_oe_n, .sample_strobe, .overflow_lost);
  adcp_capture_model u_cap (.mclk, .sample_word_o, .sample_word_oe_n,
    .over_range_flag_o, .over_range_flag_oe_n, .sample_strobe, .cap);
  always #5 mclk = ~mclk;
  task tick(int n);
    repeat (n) @(posedge mclk);
  endtask
  // 10 mclk per sample leaves margin for the two-flop pin synchroniser
  task samp(logic [ADCP_CODE_W:0] v, bit chk);
    adcp_result_s e;
    e.over_range_flag = v > ADCP_RAW_TOP;
    e.sample_word = e.over_range_flag ? ADCP_FULL_SCALE : v[ADCP_CODE_W-1:0];
    exp_q.push_back(e);
    raw_level <= v;
    sample_clk <= 1'b1;
    tick(5);
    sample_clk <= 1'b0;
    tick(5);
    if (chk && exp_q.size() > ADCP_LATENCY)
      `CHK("capture", exp_q[exp_q.size()-1-ADCP_LATENCY], cap)
  endtask
  task t_codes();
    foreach (CODES[i]) samp(CODES[i], 1);
  endtask
  task t_oe();
    output_enable_n <= 1'b1;
    #1;
    `CHK("oe_float", 11'h7FF, {over_range_flag_oe_n, sample_word_oe_n})
    @(posedge mclk);
    samp(11'h123, 0);
    samp(11'h321, 0);
    samp(11'h0F0, 0);
    samp(11'h1C3, 0);
    `CHK("reg_kept", 10'h123, sample_word_o)
    output_enable_n <= 1'b0;
    #1;
    `CHK("oe_drive", 11'h000, {over_range_flag_oe_n, sample_word_oe_n})
    @(posedge mclk);
  endtask
  task t_sleep();
    int n;
    sleep_control <= 1'b1;
    tick(2);
    `CHK("sleep_float", 11'h7FF, {over_range_flag_oe_n, sample_word_oe_n})
    samp(11'h055, 0);
    exp_q.delete();
    sleep_control <= 1'b0;
    tick(8);
    samp(11'h011, 1);
    samp(11'h022, 1);
    samp(11'h033, 1);
    sample_clk <= 1'b1;
    for (n = 0; sample_strobe !== 1'b1; n++) begin
      if (n > 20) begin
        errors++;
        disable scen;
      end
      @(posedge mclk);
      #1;
    end
    `CHK("after_wake", 10'h011, sample_word_o)
    sample_clk <= 1'b0;
    tick(5);
  endtask
  task end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    begin : scen
      tick(3);
      nrst <= 1'b1;
      tick(8);
      t_codes();
      t_oe();
      t_sleep();
    end
    end_sim();
  end
endmodule
